// [verilog/urx_params.svh]
// Constants for the receive-command status reporter.
`ifndef URX_PARAMS_SVH
`define URX_PARAMS_SVH

// Bit positions inside the status byte.
`define URX_POS_LINE 0
`define URX_POS_VBUS 2
`define URX_POS_EVENT 4
`define URX_POS_ID 6
`define URX_POS_ALT 7

// Encoded supply voltage state.
`define URX_VBUS_BELOW_END 2'h0
`define URX_VBUS_ABOVE_END 2'h1
`define URX_VBUS_SESS_VALID 2'h2
`define URX_VBUS_A_VALID 2'h3

// Encoded receive events.
`define URX_EVT_NONE 2'h0
`define URX_EVT_ACTIVE 2'h1
`define URX_EVT_ERROR 2'h3
`define URX_EVT_DISCONNECT 2'h2

// Line-state codes used in high-speed and chirp modes.
`define URX_LS_SQUELCH 2'h0
`define URX_LS_NO_SQUELCH 2'h1
`define URX_LS_CHIRP_HIGH 2'h1
`define URX_LS_CHIRP_LOW 2'h2

// Transceiver select and operating mode codes.
`define URX_XCVR_HS 2'h0
`define URX_OPMODE_CHIRP 2'h2

// Reset values.
`define URX_IDLE_BYTE 8'h00
`define URX_SENT_RST 7'h00
`define URX_WARM_RST 3'h0

// Synchroniser depth for pin inputs.
`define URX_SYNC_STAGES 2

`endif

// [verilog/urx_pkg.sv]
// Types shared by the receive-command status reporter.
package urx_pkg;

    // Role and speed configuration from the register block.
    typedef struct packed {
        logic [1:0] xcvr_select;
        logic term_select;
        logic [1:0] opmode;
        logic dp_pulldown;
        logic dm_pulldown;
    } urx_cfg_s;

    // Analog comparator and pin levels, asynchronous to core_clk.
    typedef struct packed {
        logic dp_se;
        logic dm_se;
        logic hs_squelch;
        logic hs_diff;
        logic session_end_indicator;
        logic session_valid_indicator;
        logic a_device_vbus_valid;
        logic id_pin;
        logic bvalid;
        logic host_disconnect;
    } urx_ana_s;

    // Status byte layout, most significant field first.
    typedef struct packed {
        logic alternate_event_flag;
        logic id;
        logic [1:0] rx_event;
        logic [1:0] vbus;
        logic [1:0] line;
    } urx_rxcmd_s;

    typedef enum logic [1:0] {
        URX_IDLE,
        URX_TURN,
        URX_SEND
    } urx_state_e;

endpackage

// [verilog/urx_sync.sv]
// Two-stage synchroniser for a group of asynchronous levels.
`include "urx_params.svh"

module urx_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [`URX_SYNC_STAGES-1:0] stage_r [WIDTH];

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge core_clk or negedge arst_n)
            begin
                if (!arst_n)
                    stage_r[i] <= '0;
                else
                    stage_r[i] <= {stage_r[i][`URX_SYNC_STAGES-2:0], async_in[i]};
            end
            assign sync_out[i] = stage_r[i][`URX_SYNC_STAGES-1];
        end
    endgenerate

endmodule // urx_sync

// [verilog/urx_linestate.sv]
// Line-state code from the line receivers, per role and speed.
`include "urx_params.svh"

module urx_linestate (
    // Configuration
    input wire urx_pkg::urx_cfg_s cfg,
    // Receiver levels
    input wire logic dp_se,
    input wire logic dm_se,
    input wire logic hs_squelch,
    input wire logic hs_diff,
    // Code
    output logic [1:0] line
);

    logic host_role;
    logic hs_xcvr;
    logic chirp;

    always_comb
    begin
        host_role = cfg.dp_pulldown && cfg.dm_pulldown;
        hs_xcvr = (cfg.xcvr_select == `URX_XCVR_HS);
        // Peripheral chirps with termination on; host chirps with it off and opmode chirp.
        if (host_role)
            chirp = hs_xcvr && !cfg.term_select && (cfg.opmode == `URX_OPMODE_CHIRP); // R15
        else
            chirp = hs_xcvr && cfg.term_select; // R13
        if (chirp)
            line = hs_squelch ? `URX_LS_SQUELCH : (hs_diff ? `URX_LS_CHIRP_HIGH : `URX_LS_CHIRP_LOW); // R13 R15
        else if (hs_xcvr && !(host_role && cfg.term_select))
            line = hs_squelch ? `URX_LS_SQUELCH : `URX_LS_NO_SQUELCH; // R13 R15
        else
            // Raw single-ended levels give SE0, J, K, SE1 at full speed and K, J at low speed.
            // A host on the high-speed transceiver with termination on has no listed code, so it gets these too.
            line = {dm_se, dp_se}; // R11 R12 R14
    end

endmodule // urx_linestate

// [verilog/urx_reporter.sv]
// Status byte reporter: builds and sends receive-command bytes on the bus.
// Notes on behaviour
// R1: Take bus with direction, drive one status byte.
// R2: Send byte whenever any field changes.
// R3: Link accepts status bytes at any time.
// R4: Skip byte if cause vanished during low power.
// R5: Bits 1..0 carry line state.
// R6: Bits 3..2 carry encoded supply state.
// R7: Bits 5..4 carry encoded receive event.
// R8: Bit 6 carries sampled cable id level.
// R9: Enabled session edges send byte with bit 7.
// R10: Line state tracks lines; change sends byte.
// R11: Line code meaning follows role and speed.
// R12: Peripheral full speed: SE0, J, K, SE1.
// R13: Peripheral high speed squelch; chirp uses differential.
// R14: Host low/full speed codes per speed.
// R15: Host high speed and chirp codes by opmode.
// R16: Dual-role link decodes per current role.
// R17: Supply state encodes four voltage bands.
// R18: Receive event encodes active, error, disconnect.
// R19: On receive error drop next, report error.
// R20: Pending byte always carries latest field values.
`include "urx_params.svh"

module urx_reporter (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Analog levels and pins
    input wire urx_pkg::urx_ana_s ana,
    // Configuration from the register block
    input wire urx_pkg::urx_cfg_s cfg,
    input wire logic bvalid_rise_en,
    input wire logic bvalid_fall_en,
    input wire logic low_power,
    // Receive datapath
    input wire logic rx_active,
    input wire logic rx_error,
    input wire logic rx_dir,
    input wire logic rx_nxt,
    input wire logic rx_oe,
    input wire logic [7:0] rx_data,
    // Bus pins
    output logic ulpi_dir,
    output logic ulpi_nxt,
    output logic [7:0] ulpi_data_out,
    output logic ulpi_data_oe,
    // Status toward the receive datapath
    output logic rxcmd_busy,
    output logic rxcmd_sent
);

    ////////////////////////////////////////////////////////////////////////////

    urx_pkg::urx_ana_s ana_s;
    logic [1:0] line;

    urx_sync #(
        .WIDTH($bits(urx_pkg::urx_ana_s))
    ) u_sync (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .async_in(ana),
        .sync_out(ana_s)
    );

    urx_linestate u_linestate (
        .cfg(cfg),
        .dp_se(ana_s.dp_se),
        .dm_se(ana_s.dm_se),
        .hs_squelch(ana_s.hs_squelch),
        .hs_diff(ana_s.hs_diff),
        .line(line)
    );

    ////////////////////////////////////////////////////////////////////////////

    urx_pkg::urx_state_e state_r;
    urx_pkg::urx_state_e state_nxt;
    logic [6:0] sent_r;
    logic [6:0] sent_nxt;
    logic alt_r;
    logic alt_nxt;
    logic bvalid_d_r;
    logic dir_r;
    logic dir_nxt;
    logic nxt_r;
    logic nxt_out_nxt;
    logic [7:0] data_r;
    logic [7:0] data_nxt;
    logic oe_r;
    logic oe_nxt;
    logic busy_r;
    logic sent_pulse_r;
    logic sent_pulse_nxt;
    urx_pkg::urx_rxcmd_s cur;
    logic host_role;
    logic alt_set;
    logic changed;
    logic may_send;
    logic [2:0] warm_r;
    logic [2:0] warm_nxt;

    // Current field values.
    always_comb
    begin
        host_role = cfg.dp_pulldown && cfg.dm_pulldown;
        cur.line = line; // R5 R10
        if (ana_s.a_device_vbus_valid)
            cur.vbus = `URX_VBUS_A_VALID; // R17
        else if (ana_s.session_valid_indicator)
            cur.vbus = `URX_VBUS_SESS_VALID; // R17
        else if (!ana_s.session_end_indicator)
            cur.vbus = `URX_VBUS_ABOVE_END; // R17
        else
            cur.vbus = `URX_VBUS_BELOW_END; // R17
        // Disconnect only means something in host role.
        if (host_role && ana_s.host_disconnect)
            cur.rx_event = `URX_EVT_DISCONNECT; // R18
        else if (rx_active && rx_error)
            cur.rx_event = `URX_EVT_ERROR; // R18 R19
        else if (rx_active)
            cur.rx_event = `URX_EVT_ACTIVE; // R18
        else
            cur.rx_event = `URX_EVT_NONE; // R18
        cur.id = ana_s.id_pin; // R8
        cur.alternate_event_flag = alt_r; // R9
    end

    ////////////////////////////////////////////////////////////////////////////

    // Comparing against the last byte sent, not queueing snapshots, means a byte
    // always carries the newest values and a cause that vanished in low power
    // simply leaves nothing to send.
    always_comb
    begin
        // The synchroniser and edge detector leave reset as zeros, not as the pin levels, so nothing
        // is reported until both hold real levels; otherwise a false supply state would go out.
        warm_nxt = {warm_r[1:0], 1'b1};
        alt_set = warm_r[2] && ((ana_s.bvalid && !bvalid_d_r && bvalid_rise_en) ||
                  (!ana_s.bvalid && bvalid_d_r && bvalid_fall_en)); // R9
        changed = (cur[6:0] != sent_r) || alt_r; // R2 R20
        may_send = changed && !low_power && warm_r[2]; // R4
        state_nxt = state_r;
        sent_nxt = sent_r;
        alt_nxt = alt_r;
        dir_nxt = 1'b0;
        nxt_out_nxt = 1'b0;
        data_nxt = `URX_IDLE_BYTE;
        oe_nxt = 1'b0;
        sent_pulse_nxt = 1'b0;
        case (state_r)
            urx_pkg::URX_IDLE:
            begin
                if (rx_dir)
                begin
                    dir_nxt = 1'b1;
                    oe_nxt = rx_oe;
                    data_nxt = rx_data;
                    nxt_out_nxt = rx_nxt && !rx_error; // R19
                    // A byte slips into the packet on any owned cycle with output enable on and next low or a receive error.
                    if (rx_oe && (!rx_nxt || rx_error) && may_send)
                    begin
                        data_nxt = cur; // R2 R3 R19
                        sent_nxt = cur[6:0];
                        alt_nxt = 1'b0;
                        sent_pulse_nxt = 1'b1;
                    end
                end
                else if (may_send)
                begin
                    dir_nxt = 1'b1; // R1
                    state_nxt = urx_pkg::URX_TURN;
                end
            end
            urx_pkg::URX_TURN:
            begin
                dir_nxt = 1'b1; // R1
                oe_nxt = 1'b1;
                data_nxt = cur; // R20
                sent_nxt = cur[6:0];
                alt_nxt = 1'b0;
                sent_pulse_nxt = 1'b1;
                state_nxt = urx_pkg::URX_SEND;
            end
            urx_pkg::URX_SEND:
            begin
                // Holding the bus for a follow-up byte saves two turnaround cycles.
                if (may_send)
                begin
                    dir_nxt = 1'b1; // R2
                    oe_nxt = 1'b1;
                    data_nxt = cur;
                    sent_nxt = cur[6:0];
                    alt_nxt = 1'b0;
                    sent_pulse_nxt = 1'b1;
                end
                else
                begin
                    state_nxt = urx_pkg::URX_IDLE;
                end
            end
            default:
            begin
                state_nxt = urx_pkg::URX_IDLE;
            end
        endcase
        // A new edge in the sending cycle wins over the clear.
        if (alt_set)
            alt_nxt = 1'b1; // R9
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= urx_pkg::URX_IDLE;
            sent_r <= `URX_SENT_RST;
            alt_r <= 1'b0;
            bvalid_d_r <= 1'b0;
            dir_r <= 1'b0;
            nxt_r <= 1'b0;
            data_r <= `URX_IDLE_BYTE;
            oe_r <= 1'b0;
            busy_r <= 1'b0;
            sent_pulse_r <= 1'b0;
            warm_r <= `URX_WARM_RST;
        end
        else
        begin
            warm_r <= warm_nxt;
            state_r <= state_nxt;
            sent_r <= sent_nxt;
            alt_r <= alt_nxt;
            bvalid_d_r <= ana_s.bvalid;
            dir_r <= dir_nxt;
            nxt_r <= nxt_out_nxt;
            data_r <= data_nxt;
            oe_r <= oe_nxt;
            busy_r <= (state_nxt != urx_pkg::URX_IDLE);
            sent_pulse_r <= sent_pulse_nxt;
        end
    end

    assign ulpi_dir = dir_r;
    assign ulpi_nxt = nxt_r;
    assign ulpi_data_out = data_r;
    assign ulpi_data_oe = oe_r;
    assign rxcmd_busy = busy_r;
    assign rxcmd_sent = sent_pulse_r;

    ////////////////////////////////////////////////////////////////////////////

    // A launched frame turns around once and then shows a status byte.
    turn_then_byte_a: assert property ( // R1
        @(posedge core_clk) disable iff (!arst_n)
        (state_r == urx_pkg::URX_IDLE && !rx_dir && may_send)
        |=> ulpi_dir && !ulpi_data_oe ##1 ulpi_dir && ulpi_data_oe && !ulpi_nxt && rxcmd_sent)
        else $error("status frame did not turn around then drive a byte");

    change_sends_a: assert property ( // R2
        @(posedge core_clk) disable iff (!arst_n)
        (state_r == urx_pkg::URX_IDLE && !rx_dir && may_send) |-> ##[1:2] rxcmd_sent)
        else $error("field change did not send a status byte");

    line_field_a: assert property ( // R5
        @(posedge core_clk) disable iff (!arst_n)
        (state_r == urx_pkg::URX_TURN) |=> ulpi_data_out[`URX_POS_LINE+:2] == $past(line))
        else $error("line state bits wrong in status byte");

    vbus_field_a: assert property ( // R6
        @(posedge core_clk) disable iff (!arst_n)
        (state_r == urx_pkg::URX_TURN && ana_s.a_device_vbus_valid)
        |=> ulpi_data_out[`URX_POS_VBUS+:2] == `URX_VBUS_A_VALID)
        else $error("supply state bits wrong in status byte");

    event_field_a: assert property ( // R7
        @(posedge core_clk) disable iff (!arst_n)
        (state_r == urx_pkg::URX_TURN && rx_active && !rx_error && !ana_s.host_disconnect)
        |=> ulpi_data_out[`URX_POS_EVENT+:2] == `URX_EVT_ACTIVE)
        else $error("receive event bits wrong in status byte");

    id_field_a: assert property ( // R8
        @(posedge core_clk) disable iff (!arst_n)
        (state_r == urx_pkg::URX_TURN) |=> ulpi_data_out[`URX_POS_ID] == $past(ana_s.id_pin))
        else $error("id bit wrong in status byte");

    alt_edge_a: assert property ( // R9
        @(posedge core_clk) disable iff (!arst_n)
        (warm_r[2] && bvalid_rise_en && ana_s.bvalid && !bvalid_d_r) |=> alt_r)
        else $error("enabled session edge did not raise the alternate flag");

    lp_quiet_a: assert property ( // R4
        @(posedge core_clk) disable iff (!arst_n)
        (low_power && state_r == urx_pkg::URX_IDLE && !rx_dir) |=> !ulpi_dir)
        else $error("bus taken during low power");

    err_drop_a: assert property ( // R19
        @(posedge core_clk) disable iff (!arst_n)
        (rx_dir && rx_error && state_r == urx_pkg::URX_IDLE) |=> !ulpi_nxt)
        else $error("next not dropped on receive error");

    inline_error_a: assert property ( // R19
        @(posedge core_clk) disable iff (!arst_n)
        (state_r == urx_pkg::URX_IDLE && rx_dir && rx_oe && rx_active && rx_error && may_send &&
         !(host_role && ana_s.host_disconnect))
        |=> !ulpi_nxt && rxcmd_sent && ulpi_data_out[`URX_POS_EVENT+:2] == `URX_EVT_ERROR)
        else $error("receive error not reported inside the packet");

endmodule // urx_reporter

// [tb/urx_link_model.sv]
// Link-side model that collects status bytes from the bus.
module urx_link_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Bus pins
    input wire logic ulpi_dir,
    input wire logic ulpi_nxt,
    input wire logic [7:0] ulpi_data_out,
    input wire logic ulpi_data_oe,
    // Collected bytes
    output logic got,
    output logic [7:0] got_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic dir_q;
    ////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            dir_q <= 1'h0;
        else
            dir_q <= ulpi_dir;
    end
    // The first owned cycle is a turnaround, so a byte there is never status.
    assign got = ulpi_dir && dir_q && ulpi_data_oe && !ulpi_nxt;
    assign got_byte = ulpi_data_out;
endmodule // urx_link_model

// [tb/tb_ulpi_rxcmd_status_reporter.sv]
// Self-checking bench for the status byte reporter.
module tb_ulpi_rxcmd_status_reporter;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, arst_n, bvalid_rise_en, bvalid_fall_en, low_power;
    logic rx_active, rx_error, rx_dir, rx_nxt, rx_oe, got;
    logic ulpi_dir, ulpi_nxt, ulpi_data_oe, rxcmd_busy, rxcmd_sent;
    logic [7:0] rx_data, ulpi_data_out, got_byte;
    urx_pkg::urx_ana_s ana;
    urx_pkg::urx_cfg_s cfg;
    logic [7:0] exp_q[$];
    logic [6:0] last;
    logic [6:0] cfg_tab [11] = '{7'h30, 7'h70, 7'h00, 7'h10, 7'h53, 7'h33, 7'h03, 7'h07, 7'h0F, 7'h0B, 7'h13};
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;
    ////////////////////////////////////////////////////////////
    urx_reporter dut (.core_clk(core_clk), .arst_n(arst_n), .ana(ana), .cfg(cfg),
        .bvalid_rise_en(bvalid_rise_en), .bvalid_fall_en(bvalid_fall_en), .low_power(low_power),
        .rx_active(rx_active), .rx_error(rx_error), .rx_dir(rx_dir), .rx_nxt(rx_nxt), .rx_oe(rx_oe),
        .rx_data(rx_data), .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt), .ulpi_data_out(ulpi_data_out),
        .ulpi_data_oe(ulpi_data_oe), .rxcmd_busy(rxcmd_busy), .rxcmd_sent(rxcmd_sent));
    urx_link_model link (.core_clk(core_clk), .arst_n(arst_n), .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt),
        .ulpi_data_out(ulpi_data_out), .ulpi_data_oe(ulpi_data_oe), .got(got), .got_byte(got_byte));
    ////////////////////////////////////////////////////////////
    initial
    begin
        core_clk = 1'h0;
        forever #2 core_clk = ~core_clk;
    end
    function automatic logic [6:0] fields();
        logic [1:0] ls, vb, ev;
        logic host, chirp;
        host = cfg.dp_pulldown && cfg.dm_pulldown;
        chirp = host ? cfg.opmode == 2'h2 : cfg.term_select;
        ls = {ana.dm_se, ana.dp_se};
        if (cfg.xcvr_select == 2'h0 && !(host && cfg.term_select))
            ls = ana.hs_squelch ? 2'h0 : (chirp && !ana.hs_diff ? 2'h2 : 2'h1);
        vb = ana.a_device_vbus_valid ? 2'h3 : ana.session_valid_indicator ? 2'h2 :
            ana.session_end_indicator ? 2'h0 : 2'h1;
        ev = host && ana.host_disconnect ? 2'h2 : {rx_active && rx_error, rx_active};
        return {ana.id_pin, ev, vb, ls};
    endfunction
    // Bytes held back by low power or by a receive in progress are not expected yet.
    task automatic commit(input logic alt);
        logic [6:0] f;
        rx_data <= 8'($urandom);
        #1;
        f = fields();
        if (alt || (!low_power && !(rx_dir && rx_nxt && !rx_error) && f !== last))
        begin
            exp_q.push_back({alt, f});
            last = f;
        end
        repeat (10) @(posedge core_clk);
        check_count++;
        if (exp_q.size() != 0 || rxcmd_busy !== 1'h0)
        begin
            $display("mismatch at %0t: status byte missing or frame not closed", $time);
            n_errors++;
            exp_q.delete();
        end
    endtask
    task stop_test();
        if (n_errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    always @(negedge core_clk)
    begin
        if (got === 1'h1)
        begin
            check_count++;
            if (exp_q.size() == 0)
            begin
                $display("mismatch at %0t: unexpected byte %h", $time, got_byte);
                n_errors++;
            end
            else if (got_byte !== exp_q[0] || rxcmd_sent !== 1'h1)
            begin
                $display("mismatch at %0t: byte %h expected %h", $time, got_byte, exp_q[0]);
                n_errors++;
            end
            if (exp_q.size() != 0)
                void'(exp_q.pop_front());
        end
    end
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            stop_test();
        end
    end
    ////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(32'h29f1));
        arst_n = 1'h0;
        ana = '0;
        ana.session_end_indicator = 1'h1;
        cfg = 7'h30;
        {bvalid_rise_en, bvalid_fall_en, low_power} = 3'h0;
        {rx_active, rx_error, rx_dir, rx_nxt, rx_oe} = 5'h0;
        rx_data = 8'h00;
        last = 7'h00;
        repeat (3) @(posedge core_clk);
        arst_n <= 1'h1;
        commit(1'h0);
        // The role changes alone: a pin change still in the synchroniser would be reported once per role.
        for (int i = 0; i < 11; i++)
        begin
            @(posedge core_clk);
            cfg <= cfg_tab[i];
            commit(1'h0);
            for (int j = 0; j < 4; j++)
            begin
                @(posedge core_clk);
                {ana.hs_squelch, ana.hs_diff, ana.dm_se, ana.dp_se} <= {j[1:0], 2'($urandom)};
                commit(1'h0);
            end
        end
        @(posedge core_clk);
        cfg <= 7'h30;
        commit(1'h0);
        for (int k = 0; k < 6; k++)
        begin
            @(posedge core_clk);
            {ana.dm_se, ana.dp_se} <= {ana.dm_se, ana.dp_se} ^ 2'(1 + $urandom % 3);
            commit(1'h0);
        end
        for (int k = 0; k < 4; k++)
        begin
            @(posedge core_clk);
            {ana.a_device_vbus_valid, ana.session_valid_indicator, ana.session_end_indicator} <= 3'(8'h01 << k);
            commit(1'h0);
        end
        @(posedge core_clk);
        ana.id_pin <= 1'h1;
        commit(1'h0);
        @(posedge core_clk);
        rx_active <= 1'h1;
        commit(1'h0);
        @(posedge core_clk);
        rx_error <= 1'h1;
        commit(1'h0);
        @(posedge core_clk);
        {rx_active, rx_error, cfg} <= {2'h0, 7'h33};
        commit(1'h0);
        @(posedge core_clk);
        ana.host_disconnect <= 1'h1;
        commit(1'h0);
        @(posedge core_clk);
        cfg <= 7'h30;
        commit(1'h0);
        @(posedge core_clk);
        bvalid_rise_en <= 1'h1;
        ana.bvalid <= 1'h1;
        commit(1'h1);
        @(posedge core_clk);
        ana.bvalid <= 1'h0;
        commit(1'h0);
        @(posedge core_clk);
        bvalid_fall_en <= 1'h1;
        ana.bvalid <= 1'h1;
        commit(1'h1);
        @(posedge core_clk);
        ana.bvalid <= 1'h0;
        commit(1'h1);
        @(posedge core_clk);
        {low_power, ana.id_pin} <= 2'h2;
        commit(1'h0);
        @(posedge core_clk);
        ana.id_pin <= 1'h1;
        commit(1'h0);
        @(posedge core_clk);
        low_power <= 1'h0;
        commit(1'h0);
        @(posedge core_clk);
        {low_power, ana.id_pin} <= 2'h2;
        commit(1'h0);
        @(posedge core_clk);
        low_power <= 1'h0;
        commit(1'h0);
        @(posedge core_clk);
        {rx_dir, rx_oe, rx_nxt, rx_active} <= 4'hF;
        commit(1'h0);
        check_count++;
        if (ulpi_nxt !== 1'h1 || ulpi_dir !== 1'h1)
        begin
            $display("mismatch at %0t: receive not passed through", $time);
            n_errors++;
        end
        @(posedge core_clk);
        rx_error <= 1'h1;
        #1;
        last = fields();
        exp_q.push_back({1'h0, last});
        // The receive path ends a failed packet at once; held longer, its own data would show with next low.
        @(posedge core_clk);
        {rx_dir, rx_oe, rx_nxt, rx_active, rx_error} <= 5'h00;
        commit(1'h0);
        stop_test();
    end
endmodule // tb_ulpi_rxcmd_status_reporter
